// *** core/hpc_map.vh ***
`ifndef HPC_MAP_VH
`define HPC_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define HPC_A_CFG       8'h00
`define HPC_A_GECTL     8'h04
`define HPC_A_GESTS     8'h08
`define HPC_A_SWPM      8'h0C
`define HPC_A_PORT_HI   3'h1
`define HPC_R_CAP       2'h0
`define HPC_R_CTL       2'h1
`define HPC_R_STS       2'h2
`define HPC_R_INT       2'h3

// ****************************************
// hotplug_config_reg fields
// ****************************************
`define HPC_INV_AB      0
`define HPC_INV_PD      1
`define HPC_INV_PF      2
`define HPC_INV_ML      3
`define HPC_INV_AI      4
`define HPC_INV_PI      5
`define HPC_INV_PE      6
`define HPC_INV_IL      7
`define HPC_INV_PG      8
`define HPC_TOGGLE      9
`define HPC_SUBST       10
`define HPC_AUTO_OFF    11
`define HPC_PIN_SEL     12
`define HPC_RX_SEL      13
`define HPC_GPIO7_ALT   14
`define HPC_CFG_W       15
`define HPC_CFG_RST     15'h0000

// ****************************************
// slot control / status fields
// ****************************************
`define HPC_EV_AB       0
`define HPC_EV_PF       1
`define HPC_EV_ML       2
`define HPC_EV_PD       3
`define HPC_EV_CC       4
`define HPC_HOTPLUG_INTERRUPT_ENABLE        5
`define HPC_AI_CTL      6
`define HPC_PI_CTL      7
`define HPC_PCC         8
`define HPC_IL_CTL      9
`define HPC_CTL_RST     9'h000
`define HPC_ST_LATCH    5
`define HPC_ST_PRES     6
`define HPC_ST_IL       7

// ****************************************
// timing
// ****************************************
`define HPC_CLK_MHZ     100
`define HPC_ILOCK_MS    125
`define HPC_ILOCK_CYC   (`HPC_ILOCK_MS * 1000 * `HPC_CLK_MHZ)

`endif

// *** core/hpc_ctrl.v ***
`timescale 1ns/1ps
`include "hpc_map.vh"

module hpc_ctrl #(
    parameter ILOCK_CYC = `HPC_ILOCK_CYC
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        eeprom_load_active,
    input  wire [1:0]  attention_button_in,
    input  wire [1:0]  presence_in,
    input  wire [1:0]  power_fault_in,
    input  wire [1:0]  retention_latch_in,
    input  wire [1:0]  slot_power_good_in,
    input  wire [1:0]  link_receiver_detect,
    output wire [1:0]  attention_indicator_out,
    output wire [1:0]  power_indicator_out,
    output wire [1:0]  slot_power_enable_out,
    output wire [1:0]  interlock_out,
    output reg  [1:0]  msi_req,
    output wire [1:0]  intx_out,
    output reg  [1:0]  pme_req,
    output wire        gpio7_out,
    output wire        gpio7_oe
);

    // ****************************************
    // bus slave
    // ****************************************
    reg                  ack_q;
    reg [`HPC_CFG_W-1:0] cfg_q;
    reg [1:0]            gectl_q;
    reg [1:0]            gests_q;
    reg                  sw_d3_q;
    wire                 req;
    wire                 wr_ok;
    wire                 port_hit;
    wire [1:0]           gest_set;
    wire [31:0]          prt_rd [0:1];

    // byte offset compare for global registers
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // per-port register select: port index and word
    function psel;
        input [7:0] a;
        input       p;
        input [1:0] r;
        begin
            psel = (a[7:5] == `HPC_A_PORT_HI) && (a[4] == p) && (a[3:2] == r) && (a[1:0] == 2'b00);
        end
    endfunction

    // one wait cycle, then answer
    // waitrequest is combinational, so the master sees it in the first cycle
    // ack_q clears after the answer edge: back-to-back requests each wait once
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_ok           = avs_write & ack_q;
    assign port_hit        = (avs_address[7:5] == `HPC_A_PORT_HI) && (avs_address[1:0] == 2'b00);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // read data captured in the wait cycle
    // registered here, so the address decode stays off the read data path
    // and the word stands at the edge where waitrequest is low
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            if (hit(avs_address, `HPC_A_CFG))
                avs_readdata <= {17'h0_0000, cfg_q};
            else if (hit(avs_address, `HPC_A_GECTL))
                avs_readdata <= {30'h0000_0000, gectl_q};
            else if (hit(avs_address, `HPC_A_GESTS))
                avs_readdata <= {30'h0000_0000, gests_q};
            else if (hit(avs_address, `HPC_A_SWPM))
                avs_readdata <= {31'h0000_0000, sw_d3_q};
            else if (port_hit)
                avs_readdata <= prt_rd[avs_address[4]];
            else
                avs_readdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // global configuration registers
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q   <= `HPC_CFG_RST;
            gectl_q <= 2'b00;
            sw_d3_q <= 1'b0;
        end else if (wr_ok) begin
            if (hit(avs_address, `HPC_A_CFG))
                cfg_q <= avs_writedata[`HPC_CFG_W-1:0];
            if (hit(avs_address, `HPC_A_GECTL))
                gectl_q <= avs_writedata[1:0];
            if (hit(avs_address, `HPC_A_SWPM))
                sw_d3_q <= avs_writedata[0];
        end
    end

    // general event status: set wins over write-one clear
    // a clear landing with a new event loses, so no event is dropped
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gests_q <= 2'b00;
        end else begin
            gests_q <= (gests_q & ~((wr_ok && hit(avs_address, `HPC_A_GESTS)) ? avs_writedata[1:0] : 2'b00))
                       | gest_set;
        end
    end

    // gpio7 carries the general event only in alternate function
    // enable follows the function select alone: the pin is left to its
    // own logic until software hands it to the general event
    assign gpio7_oe  = cfg_q[`HPC_GPIO7_ALT];
    assign gpio7_out = cfg_q[`HPC_GPIO7_ALT] & (|gests_q);

    // ****************************************
    // per-port slot controller
    // ****************************************
    // index 0 serves port 2, index 1 port 3
    // both ports share one polarity word and one general event pin
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            reg        cap_q;
            reg        lpres_q;
            reg [9:0]  ctl_q;
            reg [4:0]  sts_q;
            reg        msie_q;
            reg        intx_disable_q;
            reg        d3_q;
            reg        il_q;
            reg [23:0] il_cnt_q;
            reg        ab_q;
            reg        pf_q;
            reg        ml_q;
            reg        pd_q;
            reg        pend_q;
            reg        wake_q;
            reg        gev_q;
            wire       ab;
            wire       pf;
            wire       ml;
            wire       pd;
            wire       il_stat;
            wire       ml_stat;
            wire       wr_cap;
            wire       wr_ctl;
            wire       wr_sts;
            wire       wr_int;
            wire       il_cmd;
            wire [4:0] ev_set;
            wire [4:0] unmasked;
            wire       pend;
            wire       wake;
            wire       gev;
            wire       pwr_on;
            wire       in_d3;
            wire       pidx;

            // one-bit port index for the register select
            assign pidx   = (p == 1);
            assign wr_cap = wr_ok & psel(avs_address, pidx, `HPC_R_CAP);
            assign wr_ctl = wr_ok & psel(avs_address, pidx, `HPC_R_CTL);
            assign wr_sts = wr_ok & psel(avs_address, pidx, `HPC_R_STS);
            assign wr_int = wr_ok & psel(avs_address, pidx, `HPC_R_INT);
            assign il_cmd = wr_ctl & avs_writedata[`HPC_IL_CTL] & cap_q;

            // inputs brought to active-high by polarity bits
            // one polarity bit flips a signal on both ports at once
            assign ab = attention_button_in[p] ^ cfg_q[`HPC_INV_AB];
            assign pf = power_fault_in[p] ^ cfg_q[`HPC_INV_PF];
            assign ml = retention_latch_in[p] ^ cfg_q[`HPC_INV_ML];
            // presence from pin and/or receiver detect
            assign pd = (cfg_q[`HPC_PIN_SEL] & (presence_in[p] ^ cfg_q[`HPC_INV_PD]))
                      | (cfg_q[`HPC_RX_SEL] & link_receiver_detect[p]);

            // slot capability and interrupt configuration words
            // an incapable port raises no events, takes no interlock command and holds indicators and power enable off; messages are not gated
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    cap_q   <= 1'b0;
                    lpres_q <= 1'b0;
                    msie_q  <= 1'b0;
                    intx_disable_q <= 1'b0;
                    d3_q    <= 1'b0;
                end else begin
                    if (wr_cap) begin
                        cap_q   <= avs_writedata[0];
                        lpres_q <= avs_writedata[1];
                    end
                    if (wr_int) begin
                        msie_q  <= avs_writedata[0];
                        intx_disable_q <= avs_writedata[1];
                        d3_q    <= avs_writedata[2];
                    end
                end
            end

            // slot control; interlock bit is a command, not stored
            // power controller control set means slot power off
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    ctl_q <= `HPC_CTL_RST;
                end else if (wr_ctl) begin
                    ctl_q <= {1'b0, avs_writedata[8:0]};
                end
            end

            // interlock pulse or toggle
            // a write during an active pulse is ignored, so it never stretches
            // toggle mode has no timer; counter cleared for a clean mode change
            // 24-bit counter: a longer pulse length than that will not fit
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    il_q     <= 1'b0;
                    il_cnt_q <= 24'h00_0000;
                end else if (il_cmd && cfg_q[`HPC_TOGGLE]) begin
                    il_q     <= ~il_q;
                    il_cnt_q <= 24'h00_0000;
                end else if (il_cmd && !il_q) begin
                    il_q     <= 1'b1;
                    il_cnt_q <= ILOCK_CYC[23:0]; // full length: output stands ILOCK_CYC cycles
                end else if (il_cnt_q != 24'h00_0000) begin
                    il_cnt_q <= il_cnt_q - 24'h00_0001;
                    if (il_cnt_q == 24'h00_0001)
                        il_q <= 1'b0;
                end
            end

            // latch substitution for status reporting
            // the latch input then reports the interlock, so the latch
            // sensor reads closed and cannot raise latch events
            assign il_stat = cfg_q[`HPC_SUBST] ? ml : il_q;
            assign ml_stat = cfg_q[`HPC_SUBST] ? 1'b0 : ml;

            // power enable with automatic latch-open cut
            // cut is off while the latch input is borrowed for interlock
            // status, else an engaged interlock would drop slot power
            assign pwr_on = cap_q & ~ctl_q[`HPC_PCC]
                          & ~(cfg_q[`HPC_AUTO_OFF] & lpres_q & ~cfg_q[`HPC_SUBST] & ml);

            // outputs toward the expander, polarity applied
            assign attention_indicator_out[p] = (cap_q & ctl_q[`HPC_AI_CTL]) ^ cfg_q[`HPC_INV_AI];
            assign power_indicator_out[p]     = (cap_q & ctl_q[`HPC_PI_CTL]) ^ cfg_q[`HPC_INV_PI];
            assign slot_power_enable_out[p]   = pwr_on ^ cfg_q[`HPC_INV_PE];
            assign interlock_out[p]           = il_q ^ cfg_q[`HPC_INV_IL];

            // previous input levels for change detection
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    ab_q <= 1'b0;
                    pf_q <= 1'b0;
                    ml_q <= 1'b0;
                    pd_q <= 1'b0;
                end else begin
                    ab_q <= ab;
                    pf_q <= pf; // fault is level; slot must hold it
                    ml_q <= ml_stat;
                    pd_q <= pd;
                end
            end

            // event detection; loading defaults never completes a command
            // any other write to slot control of a capable port completes a command; loading
            // runs before the expander is set up, so nothing completes then
            assign ev_set[`HPC_EV_AB] = cap_q & ab & ~ab_q;
            assign ev_set[`HPC_EV_PF] = cap_q & pf & ~pf_q;
            assign ev_set[`HPC_EV_ML] = cap_q & (ml_stat ^ ml_q);
            assign ev_set[`HPC_EV_PD] = cap_q & (pd ^ pd_q);
            assign ev_set[`HPC_EV_CC] = cap_q & wr_ctl & ~eeprom_load_active;

            // slot status: set wins over write-one clear
            // a clear in the same cycle as an event must not lose the event
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    sts_q <= 5'h00;
                end else begin
                    sts_q <= (sts_q & ~(wr_sts ? avs_writedata[4:0] : 5'h00)) | ev_set;
                end
            end

            // notification decisions
            // wake looks at the first four events only: completion never wakes
            // general event mode keeps status bits but mutes every message
            assign in_d3    = d3_q | sw_d3_q;
            assign unmasked = sts_q & ctl_q[4:0];
            assign pend     = ctl_q[`HPC_HOTPLUG_INTERRUPT_ENABLE] & (|unmasked) & ~gectl_q[p];
            assign wake     = in_d3 & (|unmasked[3:0]) & ~gectl_q[p];
            assign gev      = (|unmasked) & gectl_q[p];
            assign gest_set[p] = gev & ~gev_q;

            // edge-based message requests
            // one-cycle requests on the rise of the level, so a status
            // bit that stays set asks only once
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    pend_q     <= 1'b0;
                    wake_q     <= 1'b0;
                    gev_q      <= 1'b0;
                    msi_req[p] <= 1'b0;
                    pme_req[p] <= 1'b0;
                end else begin
                    pend_q     <= pend;
                    wake_q     <= wake;
                    gev_q      <= gev;
                    msi_req[p] <= pend & ~pend_q & msie_q;
                    pme_req[p] <= wake & ~wake_q;
                end
            end

            // legacy level interrupt when msi is off
            // drops as soon as software clears the status bits
            assign intx_out[p] = pend & ~msie_q & ~intx_disable_q;

            // read view of this port
            // latch state, presence and interlock status are live levels
            assign prt_rd[p] = (avs_address[3:2] == `HPC_R_CAP) ? {30'h0000_0000, lpres_q, cap_q} :
                               (avs_address[3:2] == `HPC_R_CTL) ? {23'h00_0000, ctl_q[8:0]} :
                               (avs_address[3:2] == `HPC_R_STS) ?
                                   {24'h00_0000, il_stat, pd, ml_stat, sts_q} :
                                   {29'h0000_0000, d3_q, intx_disable_q, msie_q};
        end
    endgenerate

endmodule // hpc_ctrl

// *** testbench/hpc_ctrl_properties.sv ***
`timescale 1ns/1ps
module hpc_ctrl_props #(
    parameter ILOCK_CYC = 20
) (
    input wire        clk,
    input wire        rst,
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [1:0]  interlock_out,
    input wire [1:0]  msi_req,
    input wire [1:0]  intx_out,
    input wire [1:0]  pme_req,
    input wire        gpio7_out,
    input wire        gpio7_oe
);
    reg  [14:0] cfg_q;
    reg  [1:0]  gectl_q;
    reg         hotplug_interrupt_enable_q;
    reg  [31:0] cnt_q;
    wire        wr_ok  = avs_write & ~avs_waitrequest;
    wire        rd_sts = avs_read & ~avs_waitrequest & (avs_address == 8'h28);
    // shadows of written control bits, interlock high-time counter
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q   <= 15'h0000;
            gectl_q <= 2'h0;
            hotplug_interrupt_enable_q  <= 1'h0;
            cnt_q   <= 32'h0000_0000;
        end else begin
            if (wr_ok && avs_address == 8'h00) cfg_q <= avs_writedata[14:0];
            if (wr_ok && avs_address == 8'h04) gectl_q <= avs_writedata[1:0];
            if (wr_ok && avs_address == 8'h24) hotplug_interrupt_enable_q <= avs_writedata[5];
            cnt_q <= interlock_out[0] ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ilock_len: assert property ($fell(interlock_out[0]) && !cfg_q[9] && !cfg_q[7] |-> cnt_q == ILOCK_CYC)
        else $error("interlock pulse length wrong");
    a_status_ilock: assert property (rd_sts && !cfg_q[10] && !cfg_q[7] |-> avs_readdata[7] == $past(interlock_out[0]))
        else $error("interlock status differs from output");
    a_latch_closed: assert property (rd_sts && cfg_q[10] |-> !avs_readdata[5])
        else $error("latch state not closed under substitution");
    a_gpio_alt: assert property (gpio7_oe == cfg_q[14])
        else $error("gpio7 driven outside alternate function");
    a_gev_mute: assert property (gectl_q[0] && $past(gectl_q[0]) |-> !msi_req[0] && !pme_req[0] && !intx_out[0])
        else $error("standard notification in general event mode");
    a_hotplug_interrupt_enable_gate: assert property (!hotplug_interrupt_enable_q && !$past(hotplug_interrupt_enable_q) |-> !msi_req[0] && !intx_out[0])
        else $error("interrupt without hotplug interrupt enable");
    a_msi_intx: assert property (msi_req[0] |-> !intx_out[0])
        else $error("msi and intx together");
    a_pme_single: assert property (pme_req[0] |=> !pme_req[0])
        else $error("wake request longer than one cycle");
    a_gests_src: assert property ($rose(gpio7_out) |-> gectl_q != 2'h0)
        else $error("general event without general event mode");
    c_pulse: cover property ($fell(interlock_out[0]) && !cfg_q[9]);
    c_wake: cover property (pme_req[0]);
    c_msi: cover property (msi_req[0]);
endmodule // hpc_ctrl_props

bind hpc_ctrl hpc_ctrl_props #(.ILOCK_CYC(ILOCK_CYC)) u_props (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .interlock_out(interlock_out), .msi_req(msi_req), .intx_out(intx_out), .pme_req(pme_req),
    .gpio7_out(gpio7_out), .gpio7_oe(gpio7_oe));

// *** testbench/hpc_slot_model.sv ***
`timescale 1ns/1ps
module hpc_slot_model (
    input  wire       clk,
    input  wire       rst,
    input  wire [1:0] ev_button,
    input  wire [1:0] ev_present,
    input  wire [1:0] ev_fault,
    input  wire [1:0] ev_latch,
    input  wire [1:0] slot_power_enable_out,
    output wire [1:0] attention_button_in,
    output wire [1:0] presence_in,
    output wire [1:0] power_fault_in,
    output wire [1:0] retention_latch_in,
    output wire [1:0] slot_power_good_in
);
    reg [1:0] pe_q;
    reg [1:0] pf_q;
    // button, presence and latch inputs mirror the slot sensors; power good follows the power enable
    assign attention_button_in = ev_button;
    assign presence_in         = ev_present;
    assign retention_latch_in  = ev_latch;
    assign slot_power_good_in  = slot_power_enable_out;
    assign power_fault_in      = pf_q;
    // fault stays up until the power enable toggles
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pe_q <= 2'h0;
            pf_q <= 2'h0;
        end else begin
            pe_q <= slot_power_enable_out;
            pf_q <= ev_fault | (pf_q & ~(pe_q ^ slot_power_enable_out));
        end
    end
endmodule // hpc_slot_model

// *** testbench/tb_hpc_ctrl.sv ***
`timescale 1ns/1ps
`define HPC_CHK(nm, ex, got) \
    begin \
        n_compared++; \
        if ((got) !== (ex)) begin \
            num_errors++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module tb_hpc_ctrl;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} hpc_row_t;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest, eeprom, gpio7_out, gpio7_oe;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0]  btn, pres, flt, lat, rx, ab, pd, pf, ml, pg, ai, pi, pe, il, msi, intx, pme;
    int          num_errors, n_compared, cyc, msi_cnt, pme_cnt;
    hpc_row_t    rows[7] = '{'{8'h20, 32'h0000_0003, 32'h0000_0003}, '{8'h30, 32'h0000_0001, 32'h0000_0001},
        '{8'h04, 32'h0000_0003, 32'h0000_0003}, '{8'h04, 32'h0000_0000, 32'h0000_0000},
        '{8'h2C, 32'h0000_0007, 32'h0000_0007}, '{8'h2C, 32'h0000_0000, 32'h0000_0000},
        '{8'h40, 32'h0000_FFFF, 32'h0000_0000}};
    logic [31:0] d3_ctl[3] = '{32'h0000_001F, 32'h0000_003F, 32'h0000_0020};
    logic [1:0]  d3_exp[3] = '{2'h1, 2'h3, 2'h0};

    hpc_ctrl #(.ILOCK_CYC(20)) dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .eeprom_load_active(eeprom), .attention_button_in(ab),
        .presence_in(pd), .power_fault_in(pf), .retention_latch_in(ml), .slot_power_good_in(pg),
        .link_receiver_detect(rx), .attention_indicator_out(ai), .power_indicator_out(pi),
        .slot_power_enable_out(pe), .interlock_out(il), .msi_req(msi), .intx_out(intx), .pme_req(pme),
        .gpio7_out(gpio7_out), .gpio7_oe(gpio7_oe));
    hpc_slot_model u_slot (.clk(clk), .rst(rst), .ev_button(btn), .ev_present(pres), .ev_fault(flt),
        .ev_latch(lat), .slot_power_enable_out(pe), .attention_button_in(ab), .presence_in(pd),
        .power_fault_in(pf), .retention_latch_in(ml), .slot_power_good_in(pg));

    // ****************
    // clock, pulse counters, watchdog
    // ****************
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        msi_cnt += msi[0];
        pme_cnt += pme[0];
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            end_sim;
        end
    end

    // ****************
    // bus and helper tasks
    // ****************
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        `HPC_CHK(nm, e, rd & m)
    endtask
    task settle;
        repeat (4) @(posedge clk);
    endtask
    task press(input logic [1:0] p);
        btn <= p;
        settle;
        btn <= 2'h0;
        settle;
    endtask
    task end_sim;
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        {rst, avs_read, avs_write, eeprom, avs_address, avs_writedata} = {1'h1, 43'h0};
        {btn, pres, flt, lat, rx} = 10'h000;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rdc("cfg_reset", 8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        `HPC_CHK("out_reset", 8'h00, {ai, pi, pe, il})
        foreach (rows[i]) begin
            bus(1'h1, rows[i].a, rows[i].d);
            rdc("reg_readback", rows[i].a, 32'hFFFF_FFFF, rows[i].e);
        end
        bus(1'h1, 8'h00, 32'h0000_2000);
        rx <= 2'h1;
        settle;
        rdc("inband_presence", 8'h28, 32'h0000_0040, 32'h0000_0040);
        bus(1'h1, 8'h00, 32'h0000_1000);
        rdc("pin_presence", 8'h28, 32'h0000_0040, 32'h0000_0000);
        bus(1'h1, 8'h28, 32'h0000_001F);
        eeprom <= 1'h1;
        bus(1'h1, 8'h24, 32'h0000_001F);
        eeprom <= 1'h0;
        rdc("load_no_cc", 8'h28, 32'h0000_0010, 32'h0000_0000);
        bus(1'h1, 8'h24, 32'h0000_003F);
        settle;
        rdc("cc_set", 8'h28, 32'h0000_0010, 32'h0000_0010);
        `HPC_CHK("intx_cc", 2'h1, intx)
        bus(1'h1, 8'h28, 32'h0000_001F);
        settle;
        `HPC_CHK("intx_clear", 2'h0, intx)
        bus(1'h1, 8'h2C, 32'h0000_0001);
        msi_cnt = 0;
        press(2'h1);
        `HPC_CHK("msi_count", 1, msi_cnt)
        `HPC_CHK("intx_msi", 2'h0, intx)
        bus(1'h1, 8'h28, 32'h0000_001F);
        bus(1'h1, 8'h2C, 32'h0000_0004);
        foreach (d3_ctl[i]) begin
            pme_cnt = 0;
            bus(1'h1, 8'h24, d3_ctl[i]);
            settle;
            `HPC_CHK("cc_no_wake", 0, pme_cnt)
            bus(1'h1, 8'h28, 32'h0000_001F);
            press(2'h1);
            `HPC_CHK("d3_wake", d3_exp[i][0], pme_cnt)
            `HPC_CHK("d3_intx", d3_exp[i][1], intx[0])
        end
        bus(1'h1, 8'h2C, 32'h0000_0000);
        bus(1'h1, 8'h24, 32'h0000_0200);
        `HPC_CHK("ilock_on", 1'h1, il[0])
        rdc("ilock_status", 8'h28, 32'h0000_0080, 32'h0000_0080);
        repeat (20) @(posedge clk);
        `HPC_CHK("ilock_off", 1'h0, il[0])
        bus(1'h1, 8'h00, 32'h0000_1200);
        bus(1'h1, 8'h24, 32'h0000_0200);
        repeat (30) @(posedge clk);
        `HPC_CHK("toggle_hold", 1'h1, il[0])
        bus(1'h1, 8'h24, 32'h0000_0200);
        `HPC_CHK("toggle_back", 1'h0, il[0])
        bus(1'h1, 8'h00, 32'h0000_1400);
        lat <= 2'h1;
        settle;
        rdc("subst_status", 8'h28, 32'h0000_00A0, 32'h0000_0080);
        bus(1'h1, 8'h00, 32'h0000_1800);
        `HPC_CHK("auto_off", 2'h2, pe)
        lat <= 2'h0;
        settle;
        `HPC_CHK("power_back", 2'h3, pe)
        flt <= 2'h1;
        @(posedge clk);
        flt <= 2'h0;
        settle;
        rdc("fault_event", 8'h28, 32'h0000_0002, 32'h0000_0002);
        `HPC_CHK("fault_held", 2'h1, pf)
        bus(1'h1, 8'h00, 32'h0000_1840);
        `HPC_CHK("pe_inverted", 2'h0, pe)
        bus(1'h1, 8'h00, 32'h0000_5000);
        `HPC_CHK("fault_release", 2'h0, pf)
        bus(1'h1, 8'h04, 32'h0000_0001);
        bus(1'h1, 8'h24, 32'h0000_001F);
        bus(1'h1, 8'h34, 32'h0000_001F);
        press(2'h3);
        `HPC_CHK("gpio7", 2'h3, {gpio7_oe, gpio7_out})
        rdc("gev_status", 8'h08, 32'h0000_0003, 32'h0000_0001);
        bus(1'h1, 8'h00, 32'h0000_1000);
        `HPC_CHK("gpio7_oe_off", 1'h0, gpio7_oe)
        bus(1'h1, 8'h34, 32'h0000_00C0);
        `HPC_CHK("indicators", 4'hA, {ai, pi})
        end_sim;
    end
endmodule // tb_hpc_ctrl
